// ---- rtl/cmr_pkg.sv ----
package cmr_pkg;

   // Bus geometry
   localparam int unsigned CMR_ADDR_W = 10;
   localparam int unsigned CMR_DATA_W = 32;
   localparam int unsigned CMR_REG_W  = 8;

   // Register indices, byte address is four times the index
   localparam logic [7:0] CMR_IDX_REF_A = 8'h9B;
   localparam logic [7:0] CMR_IDX_REF_B = 8'h9C;
   localparam logic [7:0] CMR_IDX_CTRL  = 8'h9D;
   localparam logic [7:0] CMR_IDX_AUX   = 8'hA0;

   // Control register fields
   localparam int unsigned CMR_INV_A    = 0;
   localparam int unsigned CMR_ROUTE_A  = 1;
   localparam int unsigned CMR_RES_A    = 2;
   localparam int unsigned CMR_UNUSED_L = 3;
   localparam int unsigned CMR_INV_B    = 4;
   localparam int unsigned CMR_ROUTE_B  = 5;
   localparam int unsigned CMR_RES_B    = 6;
   localparam int unsigned CMR_UNUSED_H = 7;
   localparam logic [7:0]  CMR_CTRL_WMASK = 8'h33;

   // Auxiliary register fields
   localparam int unsigned CMR_IRQ_EN   = 0;
   localparam int unsigned CMR_PWR_OFF  = 1;
   localparam int unsigned CMR_IRQ_FLAG = 7;
   localparam logic [7:0]  CMR_AUX_WMASK = 8'h03;

   // Values after reset
   localparam logic [7:0]  CMR_REG_RESET  = 8'h00;
   localparam logic [31:0] CMR_RDATA_RESET = 32'h0000_0000;

   // Reference select fields
   localparam int unsigned CMR_COARSE_LSB = 3;
   localparam int unsigned CMR_COARSE_W   = 5;
   localparam int unsigned CMR_FINE_W     = 3;
   localparam logic [4:0]  CMR_UPPER_LO = 5'h0A;
   localparam logic [4:0]  CMR_UPPER_HI = 5'h0F;
   localparam logic [4:0]  CMR_LOWER_LO = 5'h1A;

   // Flip-flops in each comparator synchroniser
   localparam int unsigned CMR_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      CMR_MIDDLE = 2'b00,
      CMR_UPPER  = 2'b01,
      CMR_LOWER  = 2'b10
   } cmr_range_t;

   typedef enum logic [1:0] {
      CMR_IDLE   = 2'b00,
      CMR_ANSWER = 2'b01
   } cmr_bus_t;

endpackage : cmr_pkg

// ---- rtl/cmr_sync2.sv ----
`timescale 1ns/1ps
module cmr_sync2
   import cmr_pkg::*;
#(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   // First stage feeds only the second stage
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : cmr_sync2

// ---- rtl/cmr_ref_decode.sv ----
`timescale 1ns/1ps
module cmr_ref_decode
   import cmr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // Reference select value
   input  wire logic [7:0]  level,
   // Ladder controls
   output logic      [4:0]  coarse,
   output logic      [2:0]  fine,
   output cmr_range_t       range
);

   wire [4:0] coarseSel = level[CMR_COARSE_LSB +: CMR_COARSE_W];
   wire [2:0] fineSel   = level[CMR_FINE_W-1:0];
   // Upper and lower ranges use the wide resistors, middle the narrow
   wire       isUpper   = (coarseSel >= CMR_UPPER_LO) &&
                          (coarseSel <= CMR_UPPER_HI);
   wire       isLower   = (coarseSel >= CMR_LOWER_LO);
   wire cmr_range_t next_range = isUpper ? CMR_UPPER :
                                 isLower ? CMR_LOWER : CMR_MIDDLE;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         coarse <= '0;
         fine   <= '0;
         range  <= CMR_MIDDLE;
      end else begin
         coarse <= coarseSel;
         fine   <= fineSel;
         range  <= next_range;
      end
   end

endmodule : cmr_ref_decode

// ---- rtl/cmr_regs.sv ----
`timescale 1ns/1ps
// Contract
// [R01] Control bits 7 and 3 read zero; writes to them are dropped.
// [R02] Control bit 6 reads comparator B output; writes do nothing.
// [R03] Control bit 2 reads comparator A output; writes do nothing.
// [R04] Bit 5 routes comparator B and reference B to pins, else port D.
// [R05] Bit 4 inverts comparator B output when set.
// [R06] Bit 1 routes comparator A and reference A to pins, else port C.
// [R07] Bit 0 inverts comparator A output when set.
// [R08] Reference A select is a full 8-bit read/write register.
// [R09] Reference B select is a full 8-bit read/write register.
// [R10] Select bits 7:3 pick coarse tap, bits 2:0 the fine step.
// [R11] Level flag is output XOR polarity; irq needs all three enables.
// [R12] Comparators and references run only while power-off is clear.
// [R13] Comparator outputs pass two flip-flops before status and flag.
// [R14] All registers clear to zero on reset.
module cmr_regs
   import cmr_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // Avalon-MM slave
   input  wire logic [CMR_ADDR_W-1:0] address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [CMR_DATA_W-1:0] writedata,
   input  wire logic [3:0]            byteenable,
   output logic      [CMR_DATA_W-1:0] readdata,
   output logic                       waitrequest,
   // Raw comparator outputs from the analog side
   input  wire logic                  compARaw,
   input  wire logic                  compBRaw,
   // CPU interrupt enables
   input  wire logic                  globalIrqEnable,
   input  wire logic                  periphIrqEnable,
   output logic                       cpuIrq,
   // Pin routing for comparator A side
   output logic                       compAPin,
   output logic                       compAPinOe,
   output logic                       refAPinRoute,
   // Pin routing for comparator B side
   output logic                       compBPin,
   output logic                       compBPinOe,
   output logic                       refBPinRoute,
   // Analog enable and ladder controls
   output logic                       analogEnable,
   output logic      [4:0]            refACoarse,
   output logic      [2:0]            refAFine,
   output cmr_range_t                 refARange,
   output logic      [4:0]            refBCoarse,
   output logic      [2:0]            refBFine,
   output cmr_range_t                 refBRange
);

   // Register state
   logic [7:0] refA;
   logic [7:0] refB;
   logic [7:0] ctrl;
   logic [7:0] aux;
   logic       irqFlag;
   cmr_bus_t   busState;

   // Synchronised comparator levels
   logic [1:0] syncOut;

   cmr_sync2 #(
      .WIDTH (2)
   ) u_sync (
      .clock (clock),
      .nrst  (nrst),
      .din   ({compBRaw, compARaw}),
      .dout  (syncOut)
   ); // see [R13]

   wire powerOff = aux[CMR_PWR_OFF];
   // A powered-down comparator reads low rather than stale data
   wire liveA    = syncOut[0] & ~powerOff; // see [R12]
   wire liveB    = syncOut[1] & ~powerOff; // see [R12]
   wire outA     = liveA ^ ctrl[CMR_INV_A]; // see [R07]
   wire outB     = liveB ^ ctrl[CMR_INV_B]; // see [R05]

   // Level flag, gated so a powered-down inverted input does not fire
   wire next_irqFlag = ~powerOff & (outA | outB); // see [R11]
   wire next_cpuIrq  = irqFlag & aux[CMR_IRQ_EN] &
                       periphIrqEnable & globalIrqEnable; // see [R11]

   // Address decode
   wire addrOk  = (address[1:0] == 2'b00);
   wire [7:0] regIdx = address[CMR_ADDR_W-1:2];
   wire hitRefA = addrOk && (regIdx == CMR_IDX_REF_A);
   wire hitRefB = addrOk && (regIdx == CMR_IDX_REF_B);
   wire hitCtrl = addrOk && (regIdx == CMR_IDX_CTRL);
   wire hitAux  = addrOk && (regIdx == CMR_IDX_AUX);

   // Read views; status bits are live, unused bits forced low
   wire [7:0] ctrlRead = {1'b0, liveB, ctrl[CMR_ROUTE_B],
                          ctrl[CMR_INV_B], 1'b0, liveA,
                          ctrl[CMR_ROUTE_A], ctrl[CMR_INV_A]}; // see [R01]
   wire [7:0] auxRead  = {irqFlag, 5'h00, aux[1:0]};
   wire [7:0] regRead  = hitRefA ? refA :
                         hitRefB ? refB :
                         hitCtrl ? ctrlRead :
                         hitAux  ? auxRead : CMR_REG_RESET;

   // A write lands on the edge where waitrequest is seen low
   wire commit  = (busState == CMR_ANSWER) && write && byteenable[0];
   wire [7:0] wByte = writedata[7:0];

   // Masking keeps status and unused bits out of the stored copy
   wire [7:0] next_ctrl = (ctrl & ~CMR_CTRL_WMASK) |
                          (wByte & CMR_CTRL_WMASK); // see [R01]
   wire [7:0] next_aux  = wByte & CMR_AUX_WMASK;

   // Bus handshake: one idle cycle, then one answer cycle
   cmr_bus_t next_busState;
   always_comb begin
      case (busState)
         CMR_IDLE: begin
            next_busState = (read || write) ? CMR_ANSWER : CMR_IDLE;
         end
         CMR_ANSWER: begin
            next_busState = CMR_IDLE;
         end
         default: begin
            next_busState = CMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busState    <= CMR_IDLE;
         waitrequest <= 1'b1;
         readdata    <= CMR_RDATA_RESET;
      end else begin
         busState    <= next_busState;
         waitrequest <= (next_busState != CMR_ANSWER);
         if (busState == CMR_IDLE && read) begin
            readdata <= {24'h00_0000, regRead}; // see [R02] [R03]
         end
      end
   end

   // Register writes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         refA <= CMR_REG_RESET; // see [R14]
         refB <= CMR_REG_RESET; // see [R14]
         ctrl <= CMR_REG_RESET; // see [R14]
         aux  <= CMR_REG_RESET; // see [R14]
      end else if (commit) begin
         if (hitRefA) begin
            refA <= wByte; // see [R08]
         end
         if (hitRefB) begin
            refB <= wByte; // see [R09]
         end
         if (hitCtrl) begin
            ctrl <= next_ctrl;
         end
         if (hitAux) begin
            aux <= next_aux;
         end
      end
   end

   // Pins, flag and enables, all registered
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqFlag      <= 1'b0;
         cpuIrq       <= 1'b0;
         compAPin     <= 1'b0;
         compAPinOe   <= 1'b0;
         refAPinRoute <= 1'b0;
         compBPin     <= 1'b0;
         compBPinOe   <= 1'b0;
         refBPinRoute <= 1'b0;
         analogEnable <= 1'b0;
      end else begin
         irqFlag      <= next_irqFlag;
         cpuIrq       <= next_cpuIrq;
         compAPin     <= outA; // see [R07]
         compAPinOe   <= ctrl[CMR_ROUTE_A]; // see [R06]
         refAPinRoute <= ctrl[CMR_ROUTE_A]; // see [R06]
         compBPin     <= outB; // see [R05]
         compBPinOe   <= ctrl[CMR_ROUTE_B]; // see [R04]
         refBPinRoute <= ctrl[CMR_ROUTE_B]; // see [R04]
         analogEnable <= ~powerOff; // see [R12]
      end
   end

   // Ladder decoding, one copy per reference
   cmr_ref_decode u_decA (
      .clock  (clock),
      .nrst   (nrst),
      .level  (refA),
      .coarse (refACoarse),
      .fine   (refAFine),
      .range  (refARange)
   ); // see [R10]

   cmr_ref_decode u_decB (
      .clock  (clock),
      .nrst   (nrst),
      .level  (refB),
      .coarse (refBCoarse),
      .fine   (refBFine),
      .range  (refBRange)
   ); // see [R10]

   unused_bits_a: assert property ( // see [R01]
      @(posedge clock) disable iff (!nrst)
      (!waitrequest && read && hitCtrl) |->
         (readdata[CMR_UNUSED_H] == 1'b0 &&
          readdata[CMR_UNUSED_L] == 1'b0 &&
          (ctrl & ~CMR_CTRL_WMASK) == 8'h00)
   ) else $error("control unused bits not zero");

   result_b_a: assert property ( // see [R02]
      @(posedge clock) disable iff (!nrst)
      (!waitrequest && read && hitCtrl) |->
         (readdata[CMR_RES_B] == $past(liveB))
   ) else $error("comparator B status mismatch");

   result_a_a: assert property ( // see [R03]
      @(posedge clock) disable iff (!nrst)
      (!waitrequest && read && hitCtrl) |->
         (readdata[CMR_RES_A] == $past(liveA))
   ) else $error("comparator A status mismatch");

   route_b_a: assert property ( // see [R04]
      @(posedge clock) disable iff (!nrst)
      (commit && hitCtrl) |=>
         ##1 (compBPinOe == $past(wByte[CMR_ROUTE_B], 2) &&
              refBPinRoute == compBPinOe)
   ) else $error("B pin routing does not follow bit 5");

   invert_b_a: assert property ( // see [R05]
      @(posedge clock) disable iff (!nrst)
      ##1 (compBPin == ($past(liveB) ^ $past(ctrl[CMR_INV_B])))
   ) else $error("B inversion wrong");

   route_a_a: assert property ( // see [R06]
      @(posedge clock) disable iff (!nrst)
      (commit && hitCtrl) |=>
         ##1 (compAPinOe == $past(wByte[CMR_ROUTE_A], 2) &&
              refAPinRoute == compAPinOe)
   ) else $error("A pin routing does not follow bit 1");

   invert_a_a: assert property ( // see [R07]
      @(posedge clock) disable iff (!nrst)
      ##1 (compAPin == ($past(liveA) ^ $past(ctrl[CMR_INV_A])))
   ) else $error("A inversion wrong");

   ref_a_write_a: assert property ( // see [R08]
      @(posedge clock) disable iff (!nrst)
      (commit && hitRefA) |=> (refA == $past(wByte))
   ) else $error("reference A write lost");

   ref_b_write_a: assert property ( // see [R09]
      @(posedge clock) disable iff (!nrst)
      (commit && hitRefB) |=> (refB == $past(wByte))
   ) else $error("reference B write lost");

   coarse_fine_a: assert property ( // see [R10]
      @(posedge clock) disable iff (!nrst)
      ##1 (refACoarse == $past(refA[7:3]) &&
           refAFine == $past(refA[2:0]) &&
           refBCoarse == $past(refB[7:3]) &&
           refBFine == $past(refB[2:0]))
   ) else $error("reference field split wrong");

   irq_gate_a: assert property ( // see [R11]
      @(posedge clock) disable iff (!nrst)
      cpuIrq |-> ($past(irqFlag) && $past(aux[CMR_IRQ_EN]) &&
                  $past(periphIrqEnable) && $past(globalIrqEnable))
   ) else $error("interrupt without all enables");

   irq_level_a: assert property ( // see [R11]
      @(posedge clock) disable iff (!nrst)
      (!powerOff && (outA || outB)) |=> irqFlag
   ) else $error("flag missed active level");

   power_off_a: assert property ( // see [R12]
      @(posedge clock) disable iff (!nrst)
      powerOff |=> (!analogEnable && !irqFlag)
   ) else $error("analog still enabled when powered off");

   sync_delay_a: assert property ( // see [R13]
      @(posedge clock) disable iff (!nrst)
      ##2 (syncOut[0] == $past(compARaw, 2) &&
           syncOut[1] == $past(compBRaw, 2))
   ) else $error("synchroniser depth not two");

   lower_range_a: assert property ( // see [R10]
      @(posedge clock) disable iff (!nrst)
      (refA[7:3] >= CMR_LOWER_LO) |=> (refARange == CMR_LOWER)
   ) else $error("reference A lower range not decoded");

   upper_range_a: assert property ( // see [R10]
      @(posedge clock) disable iff (!nrst)
      (refB[7:3] >= CMR_UPPER_LO && refB[7:3] <= CMR_UPPER_HI) |=>
         (refBRange == CMR_UPPER)
   ) else $error("reference B upper range not decoded");

   wait_state_a: assert property ( // see [R08]
      @(posedge clock) disable iff (!nrst)
      (busState == CMR_IDLE && (read || write)) |=> !waitrequest
   ) else $error("request not answered after one wait cycle");

   answer_once_a: assert property ( // see [R08]
      @(posedge clock) disable iff (!nrst)
      !waitrequest |=> waitrequest
   ) else $error("waitrequest low for more than one cycle");

   high_lanes_a: assert property ( // see [R01]
      @(posedge clock) disable iff (!nrst)
      !waitrequest |-> (readdata[31:8] == 24'h00_0000)
   ) else $error("read data upper lanes not zero");

   ctrl_mask_a: assert property ( // see [R01]
      @(posedge clock) disable iff (!nrst)
      (commit && hitCtrl) |=>
         (ctrl == ($past(wByte) & CMR_CTRL_WMASK))
   ) else $error("control write not masked");

   stray_write_a: assert property ( // see [R09]
      @(posedge clock) disable iff (!nrst)
      !commit |=> ($stable(refA) && $stable(refB) && $stable(ctrl))
   ) else $error("register changed without a write");

   reset_clear_a: assert property ( // see [R14]
      @(posedge clock)
      !nrst |=> (refA == CMR_REG_RESET && refB == CMR_REG_RESET &&
                 ctrl == CMR_REG_RESET && aux == CMR_REG_RESET &&
                 waitrequest)
   ) else $error("registers not cleared by reset");

   off_status_a: assert property ( // see [R12]
      @(posedge clock) disable iff (!nrst)
      (!waitrequest && read && hitCtrl && $past(powerOff)) |->
         (readdata[CMR_RES_A] == 1'b0 && readdata[CMR_RES_B] == 1'b0)
   ) else $error("powered-down comparator reads high");

   analog_on_a: assert property ( // see [R12]
      @(posedge clock) disable iff (!nrst)
      !powerOff |=> analogEnable
   ) else $error("analog not enabled with power-off clear");

   irq_raise_a: assert property ( // see [R11]
      @(posedge clock) disable iff (!nrst)
      (irqFlag && aux[CMR_IRQ_EN] && periphIrqEnable && globalIrqEnable)
         |=> cpuIrq
   ) else $error("interrupt missing with all enables set");

   irq_drop_a: assert property ( // see [R11]
      @(posedge clock) disable iff (!nrst)
      (powerOff || !(outA || outB)) |=> !irqFlag
   ) else $error("flag set without active level");

endmodule : cmr_regs

// ---- sim/cmr_analog_model.sv ----
`timescale 1ns/1ps
module cmr_analog_model (
   // Ladder settings and enable from the block
   input  wire logic       analogEnable,
   input  wire logic [4:0] refCoarse,
   input  wire logic [2:0] refFine,
   // Level at the comparator input
   input  wire logic [7:0] sense,
   // Comparator output, asynchronous to the core clock
   output logic            compRaw
);
   // Ladder voltage ordering is reduced to the raw select code
   assign compRaw = analogEnable && (sense > {refCoarse, refFine});
endmodule : cmr_analog_model

// ---- sim/comparator_reference_control_regs_test.sv ----
`timescale 1ns/1ps
module comparator_reference_control_regs_test
   import cmr_pkg::*;
;
   // Clock, reset and bus
   logic        clock;
   logic        nrst;
   logic [9:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   // Analog side and CPU
   logic        compARaw;
   logic        compBRaw;
   logic [7:0]  senseA;
   logic [7:0]  senseB;
   logic        globalIrqEnable;
   logic        periphIrqEnable;
   logic        cpuIrq;
   logic        analogEnable;
   // Pins and ladder controls
   logic        compAPin;
   logic        compAPinOe;
   logic        refAPinRoute;
   logic        compBPin;
   logic        compBPinOe;
   logic        refBPinRoute;
   logic [4:0]  refACoarse;
   logic [2:0]  refAFine;
   cmr_range_t  refARange;
   logic [4:0]  refBCoarse;
   logic [2:0]  refBFine;
   cmr_range_t  refBRange;
   int          nMismatch;
   int          cmpCount;

   cmr_regs dut (.clock, .nrst, .address, .read, .write, .writedata,
      .byteenable, .readdata, .waitrequest, .compARaw, .compBRaw,
      .globalIrqEnable, .periphIrqEnable, .cpuIrq, .compAPin,
      .compAPinOe, .refAPinRoute, .compBPin, .compBPinOe, .refBPinRoute,
      .analogEnable, .refACoarse, .refAFine, .refARange, .refBCoarse,
      .refBFine, .refBRange);
   cmr_analog_model modelA (.analogEnable, .refCoarse(refACoarse),
      .refFine(refAFine), .sense(senseA), .compRaw(compARaw));
   cmr_analog_model modelB (.analogEnable, .refCoarse(refBCoarse),
      .refFine(refBFine), .sense(senseB), .compRaw(compBRaw));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nMismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request is held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [7:0] idx,
      input logic [7:0] wd, input logic [3:0] be, output logic [31:0] q);
      @(posedge clock);
      address    <= {idx, 2'b00};
      read       <= rd;
      write      <= !rd;
      writedata  <= {24'h00_0000, wd};
      byteenable <= be;
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b0, idx, d, 4'hF, q);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b1, idx, 8'h00, 4'hF, q);
      chk(q[7:0], e);
      chk(q[15:8] | q[23:16] | q[31:24], 8'h00);
   endtask : rdc

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask : settle

   task automatic chkref(input logic [4:0] c, input logic [2:0] f,
      input cmr_range_t r, input logic [7:0] v);
      logic [1:0] er;
      er = (v[7:3] >= CMR_UPPER_LO && v[7:3] <= CMR_UPPER_HI) ? 2'b01 :
           (v[7:3] >= CMR_LOWER_LO) ? 2'b10 : 2'b00;
      chk(8'(c), 8'(v[7:3]));
      chk(8'(f), 8'(v[2:0]));
      chk(8'(r), 8'(er));
   endtask : chkref

   task automatic t_reset;
      rdc(CMR_IDX_REF_A, 8'h00);
      rdc(CMR_IDX_REF_B, 8'h00);
      rdc(CMR_IDX_CTRL, 8'h00);
      chk({2'b00, compAPin, compAPinOe, refAPinRoute, compBPin,
         compBPinOe, refBPinRoute}, 8'h00);
   endtask : t_reset

   // Boundary codes of each coarse range, complemented on reference B
   task automatic t_refs;
      logic [7:0]  v [6] = '{8'h50, 8'h7F, 8'h4F, 8'h80, 8'hD0, 8'hCF};
      logic [31:0] q;
      foreach (v[i]) begin
         wr(CMR_IDX_REF_A, v[i]);
         wr(CMR_IDX_REF_B, ~v[i]);
         settle(2);
         chkref(refACoarse, refAFine, refARange, v[i]);
         chkref(refBCoarse, refBFine, refBRange, ~v[i]);
         rdc(CMR_IDX_REF_A, v[i]);
         rdc(CMR_IDX_REF_B, ~v[i]);
      end
      bus(1'b0, CMR_IDX_REF_A, 8'h11, 4'h0, q);
      rdc(CMR_IDX_REF_A, 8'hCF);
   endtask : t_refs

   task automatic t_ctrl;
      wr(CMR_IDX_CTRL, 8'hFF);
      rdc(CMR_IDX_CTRL, 8'h33);
      settle(2);
      chk({4'h0, compAPinOe, refAPinRoute, compBPinOe, refBPinRoute},
         8'h0F);
      chk({6'h00, compAPin, compBPin}, 8'h03);
      wr(CMR_IDX_CTRL, 8'hCC);
      rdc(CMR_IDX_CTRL, 8'h00);
      settle(2);
      chk({4'h0, compAPinOe, refAPinRoute, compBPinOe, refBPinRoute},
         8'h00);
      chk({6'h00, compAPin, compBPin}, 8'h00);
   endtask : t_ctrl

   task automatic t_status;
      senseA <= 8'hFF;
      wr(CMR_IDX_CTRL, 8'h22);
      settle(4);
      rdc(CMR_IDX_CTRL, 8'h26);
      chk({6'h00, compAPin, compBPin}, 8'h02);
      senseA <= 8'h00;
      senseB <= 8'hFF;
      wr(CMR_IDX_CTRL, 8'h77);
      settle(4);
      rdc(CMR_IDX_CTRL, 8'h73);
      chk({6'h00, compAPin, compBPin}, 8'h02);
   endtask : t_status

   // Flag is a level; enables gate it only on the way to the CPU
   task automatic t_irq;
      globalIrqEnable <= 1'b1;
      periphIrqEnable <= 1'b1;
      wr(CMR_IDX_AUX, 8'h01);
      settle(4);
      chk(8'(cpuIrq), 8'h01);
      rdc(CMR_IDX_AUX, 8'h81);
      globalIrqEnable <= 1'b0;
      settle(3);
      chk(8'(cpuIrq), 8'h00);
      globalIrqEnable <= 1'b1;
      periphIrqEnable <= 1'b0;
      settle(3);
      chk(8'(cpuIrq), 8'h00);
      periphIrqEnable <= 1'b1;
      settle(3);
      chk(8'(cpuIrq), 8'h01);
      senseB <= 8'h00;
      wr(CMR_IDX_CTRL, 8'h00);
      settle(5);
      chk(8'(cpuIrq), 8'h00);
      rdc(CMR_IDX_AUX, 8'h01);
   endtask : t_irq

   task automatic t_power;
      senseA <= 8'hFF;
      wr(CMR_IDX_AUX, 8'h02);
      settle(5);
      chk(8'(analogEnable), 8'h00);
      rdc(CMR_IDX_CTRL, 8'h00);
      wr(CMR_IDX_AUX, 8'h00);
      settle(5);
      chk(8'(analogEnable), 8'h01);
      rdc(CMR_IDX_CTRL, 8'h04);
      // Flag is up but its own enable is off, so nothing reaches the CPU
      rdc(CMR_IDX_AUX, 8'h80);
      chk(8'(cpuIrq), 8'h00);
      wr(8'h9E, 8'hFF);
      rdc(8'h9E, 8'h00);
   endtask : t_power

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      nMismatch++;
      close_out();
   end

   initial begin
      nMismatch = 0;
      cmpCount = 0;
      nrst = 1'b0;
      address = 10'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
      senseA = 8'h00;
      senseB = 8'h00;
      globalIrqEnable = 1'b0;
      periphIrqEnable = 1'b0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_refs();
      t_ctrl();
      t_status();
      t_irq();
      t_power();
      close_out();
   end
endmodule : comparator_reference_control_regs_test
